// ### hw/sesp_slave.sv
module sesp_slave #(
  parameter logic [3:0] TYPE_CODE    = sesp_pkg::TYPE_CODE_DFLT,
  parameter int         WRITE_CYCLES = sesp_pkg::WRITE_CYCLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic linkClk,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  input  wire logic wpIn,
  output logic      sdaOut,
  output logic      sdaOe
);

  localparam int AW = sesp_pkg::ADDR_W;
  localparam int PB = sesp_pkg::PAGE_BYTES;

  if (WRITE_CYCLES < 1)
  begin : g_badCycles
    $error("WRITE_CYCLES must be at least one");
  end

  logic                  rstS1_r;
  logic                  linkRst_r;
  logic                  sclS1_r;
  logic                  sclS2_r;
  logic                  sclD_r;
  logic                  sdaS1_r;
  logic                  sdaS2_r;
  logic                  sdaD_r;
  logic                  wpS1_r;
  logic                  wpS2_r;
  logic                  doneS1_r;
  logic                  doneS2_r;
  sesp_pkg::sesp_state_t st_r;
  sesp_pkg::sesp_state_t nxt_r;
  logic [3:0]            cnt_r;
  logic [7:0]            sr_r;
  logic [7:0]            tx_r;
  logic                  sdaOe_r;
  logic [AW-1:0]         ptr_r;
  logic                  pend_r;
  logic [7:0]            pgBuf_r [PB];
  logic                  pgValid_r [PB];
  logic [7:0]            mem_r [sesp_pkg::MEM_BYTES];
  logic                  sclRise;
  logic                  sclFall;
  logic                  startEv;
  logic                  stopEv;
  logic                  busy;
  logic                  byteIn;
  logic                  bitState;
  logic                  ctrlMatch;
  logic                  wrByte;
  logic                  rdLoad;
  logic                  commit;
  logic [7:0]            memRd;

  sesp_wc_if wcIf ();

  sesp_wr_timer #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wc      (wcIf.timer)
  );

  ////////////////////////////////////////////////////////////////////////
  // reset brought into the link domain
  always_ff @(posedge linkClk)
  begin
    rstS1_r   <= sys_rst;
    linkRst_r <= rstS1_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin and completion synchronisers; a third stage gives the edge history
  always_ff @(posedge linkClk)
  begin
    if (linkRst_r)
    begin
      sclS1_r  <= 1'b1;
      sclS2_r  <= 1'b1;
      sclD_r   <= 1'b1;
      sdaS1_r  <= 1'b1;
      sdaS2_r  <= 1'b1;
      sdaD_r   <= 1'b1;
      wpS1_r   <= 1'b0;
      wpS2_r   <= 1'b0;
      doneS1_r <= 1'b0;
      doneS2_r <= 1'b0;
    end
    else
    begin
      sclS1_r  <= sclIn;
      sclS2_r  <= sclS1_r;
      sclD_r   <= sclS2_r;
      sdaS1_r  <= sdaIn;
      sdaS2_r  <= sdaS1_r;
      sdaD_r   <= sdaS2_r;
      wpS1_r   <= wpIn;
      wpS2_r   <= wpS1_r;
      doneS1_r <= wcIf.doneTgl;
      doneS2_r <= doneS1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus conditions; data is taken on the clock rise, driven after the fall
  assign sclRise = sclS2_r & ~sclD_r;
  assign sclFall = ~sclS2_r & sclD_r;
  assign startEv = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
  assign stopEv  = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;

  // busy from request until the completion toggle has come back
  assign busy = wcIf.reqTgl ^ doneS2_r;

  assign bitState  = (st_r == sesp_pkg::ST_CTRL) || (st_r == sesp_pkg::ST_WADDR)
                  || (st_r == sesp_pkg::ST_WDATA) || (st_r == sesp_pkg::ST_RDATA);
  assign byteIn    = sclFall && (cnt_r == sesp_pkg::BYTE_BITS);
  // the two bits below the type code take no part in matching
  assign ctrlMatch = (sr_r[sesp_pkg::CODE_MSB:sesp_pkg::CODE_LSB] == TYPE_CODE);
  assign wrByte    = byteIn && (st_r == sesp_pkg::ST_WDATA);
  assign rdLoad    = sclFall && (((st_r == sesp_pkg::ST_ACK) && (nxt_r == sesp_pkg::ST_RDATA))
                  || (st_r == sesp_pkg::ST_RACK));
  assign commit    = stopEv && pend_r && !wpS2_r;
  assign memRd     = mem_r[ptr_r];

  // open drain: the line is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_r;

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_ff @(posedge linkClk)
  begin
    if (linkRst_r)
    begin
      st_r    <= sesp_pkg::ST_IDLE;
      nxt_r   <= sesp_pkg::ST_IDLE;
      cnt_r   <= 4'h0;
      sr_r    <= 8'h00;
      tx_r    <= 8'h00;
      sdaOe_r <= 1'b0;
      ptr_r   <= '0;
    end
    else if (startEv)
    begin
      // a repeated start drops any write in flight but keeps the pointer
      st_r    <= sesp_pkg::ST_CTRL;
      cnt_r   <= 4'h0;
      sdaOe_r <= 1'b0;
    end
    else if (stopEv)
    begin
      st_r    <= sesp_pkg::ST_IDLE;
      sdaOe_r <= 1'b0;
    end
    else if (rdLoad)
    begin
      // fetch and drive the first bit at once, then step the pointer
      tx_r    <= memRd;
      sdaOe_r <= ~memRd[7];
      ptr_r   <= ptr_r + AW'(1);
      cnt_r   <= 4'h0;
      st_r    <= sesp_pkg::ST_RDATA;
    end
    else
    begin
      if (sclRise && bitState)
      begin
        sr_r  <= {sr_r[6:0], sdaS2_r};
        cnt_r <= cnt_r + 4'h1;
      end
      unique case (st_r)
        sesp_pkg::ST_IDLE:
        begin
          sdaOe_r <= 1'b0;
        end
        sesp_pkg::ST_CTRL:
        begin
          if (byteIn)
          begin
            cnt_r <= 4'h0;
            // no answer while the array is programming, so polling works
            if (ctrlMatch && !busy)
            begin
              sdaOe_r     <= 1'b1;
              st_r        <= sesp_pkg::ST_ACK;
              ptr_r[AW-1] <= sr_r[sesp_pkg::BLK_BIT];
              nxt_r       <= sr_r[sesp_pkg::RW_BIT] ? sesp_pkg::ST_RDATA
                                                    : sesp_pkg::ST_WADDR;
            end
            else
              st_r <= sesp_pkg::ST_IDLE;
          end
        end
        sesp_pkg::ST_ACK:
        begin
          // ack ends with the fall of the ninth clock
          if (sclFall)
          begin
            sdaOe_r <= 1'b0;
            cnt_r   <= 4'h0;
            st_r    <= nxt_r;
          end
        end
        sesp_pkg::ST_WADDR:
        begin
          if (byteIn)
          begin
            ptr_r[7:0] <= sr_r;
            sdaOe_r    <= 1'b1;
            st_r       <= sesp_pkg::ST_ACK;
            nxt_r      <= sesp_pkg::ST_WDATA;
          end
        end
        sesp_pkg::ST_WDATA:
        begin
          if (byteIn)
          begin
            // only the byte counter moves, so data wraps inside the page
            ptr_r[3:0] <= ptr_r[3:0] + 4'h1;
            sdaOe_r    <= 1'b1;
            st_r       <= sesp_pkg::ST_ACK;
            nxt_r      <= sesp_pkg::ST_WDATA;
          end
        end
        sesp_pkg::ST_RDATA:
        begin
          if (sclFall)
          begin
            if (cnt_r == sesp_pkg::BYTE_BITS)
            begin
              sdaOe_r <= 1'b0;
              st_r    <= sesp_pkg::ST_RACK;
            end
            else
            begin
              tx_r    <= {tx_r[6:0], 1'b0};
              sdaOe_r <= ~tx_r[6];
            end
          end
        end
        sesp_pkg::ST_RACK:
        begin
          // master left the line high: stop sending, line stays released
          if (sclRise && sdaS2_r)
            st_r <= sesp_pkg::ST_IDLE;
        end
        default:
        begin
          st_r    <= sesp_pkg::ST_IDLE;
          sdaOe_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending write and hand-off to the write-cycle timer
  always_ff @(posedge linkClk)
  begin
    if (linkRst_r)
    begin
      pend_r      <= 1'b0;
      wcIf.reqTgl <= 1'b0;
    end
    else if (startEv)
      pend_r <= 1'b0;
    else if (stopEv)
    begin
      pend_r <= 1'b0;
      if (commit)
        wcIf.reqTgl <= ~wcIf.reqTgl;
    end
    else if (wrByte)
      pend_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // page buffer, one slot per byte counter value; a later byte replaces an earlier one
  for (genvar i = 0; i < PB; i++)
  begin : g_page
    always_ff @(posedge linkClk)
    begin
      if (linkRst_r)
      begin
        pgBuf_r[i]   <= 8'h00;
        pgValid_r[i] <= 1'b0;
      end
      else if (startEv || stopEv)
        pgValid_r[i] <= 1'b0;
      else if (wrByte && (ptr_r[3:0] == 4'(i)))
      begin
        pgBuf_r[i]   <= sr_r;
        pgValid_r[i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array; filled only by a commit at stop, so a broken transfer changes nothing
  always_ff @(posedge linkClk)
  begin
    if (linkRst_r)
    begin
      for (int j = 0; j < sesp_pkg::MEM_BYTES; j++)
        mem_r[j] <= sesp_pkg::ERASED;
    end
    else if (commit)
    begin
      for (int j = 0; j < PB; j++)
        if (pgValid_r[j])
          mem_r[{ptr_r[AW-1:4], 4'(j)}] <= pgBuf_r[j];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (linkRst_r);

  sequence s_ctrlDone;
    byteIn && (st_r == sesp_pkg::ST_CTRL);
  endsequence

  sequence s_nack;
    sclRise && (st_r == sesp_pkg::ST_RACK) && sdaS2_r;
  endsequence

  property p_noMatch;
    s_ctrlDone ##0 !ctrlMatch |=> (st_r == sesp_pkg::ST_IDLE) && !sdaOe_r;
  endproperty
  a_noMatch: assert property (p_noMatch) else $error("foreign control byte answered");

  property p_ackCtrl;
    s_ctrlDone ##0 (ctrlMatch && !busy) |=> sdaOe_r && (st_r == sesp_pkg::ST_ACK);
  endproperty
  a_ackCtrl: assert property (p_ackCtrl) else $error("matching control byte not acked");

  property p_busyNak;
    s_ctrlDone ##0 busy |=> !sdaOe_r [*2];
  endproperty
  a_busyNak: assert property (p_busyNak) else $error("ack given during write cycle");

  property p_ackLen;
    sclFall && (st_r == sesp_pkg::ST_ACK) && (nxt_r != sesp_pkg::ST_RDATA) |=> !sdaOe_r;
  endproperty
  a_ackLen: assert property (p_ackLen) else $error("ack held past ninth clock");

  property p_addrLoad;
    byteIn && (st_r == sesp_pkg::ST_WADDR) |=> ptr_r[7:0] == $past(sr_r);
  endproperty
  a_addrLoad: assert property (p_addrLoad) else $error("word address not loaded");

  property p_pageInc;
    wrByte |=> (ptr_r[AW-1:4] == $past(ptr_r[AW-1:4])) && (ptr_r[3:0] == $past(ptr_r[3:0]) + 4'h1);
  endproperty
  a_pageInc: assert property (p_pageInc) else $error("page counter step wrong");

  property p_commit;
    stopEv && pend_r && !wpS2_r |=> busy && $changed(wcIf.reqTgl);
  endproperty
  a_commit: assert property (p_commit) else $error("write cycle not started at stop");

  property p_protect;
    stopEv && wpS2_r |=> $stable(wcIf.reqTgl);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write started a cycle");

  property p_rdInc;
    rdLoad |=> (ptr_r == $past(ptr_r) + AW'(1)) && (st_r == sesp_pkg::ST_RDATA);
  endproperty
  a_rdInc: assert property (p_rdInc) else $error("read pointer not advanced");

  property p_release;
    s_nack |=> !sdaOe_r [*2];
  endproperty
  a_release: assert property (p_release) else $error("line not released after nack");

endmodule : sesp_slave

// ### shared/sesp_pkg.sv
// Summary of operation
// - first byte after start is control byte; upper four bits must match type code
// - the two bits after the type code are ignored for matching
// - control bit before direction picks one of two 256-byte blocks, address MSB
// - direction bit: 1 requests a read, 0 requests a write
// - matching control byte is acknowledged low, then read or write handling follows
// - in a write, the next byte is the eight-bit word address
// - every received byte of a matching, non-busy transfer is acknowledged in the ninth clock period
// - received word address loads the internal address pointer
// - byte write: one data byte, acknowledged; following stop starts the write cycle
// - up to 16 data bytes are buffered and committed only after stop
// - after each data byte only the low four pointer bits increment
// - beyond 16 bytes the in-page pointer wraps and later bytes overwrite earlier ones
// - write-protect high inhibits writes to the whole array; low writes normally
// - no byte, not even the control byte, is acknowledged during the write cycle
// - address pointer holds last accessed address plus one
// - read control byte is acknowledged, bytes shift out until no acknowledge and stop
// - repeated start abandons the write but keeps the loaded address pointer
// - master acknowledge during a read makes the device send the next byte
// - during reads the pointer increments over the full address range
// - data falling with clock high is start, rising with clock high is stop
// - data changes only while clock low, sampled once per clock high period
// - without master acknowledge after a read byte, the data line is released high
package sesp_pkg;

  localparam logic [3:0] TYPE_CODE_DFLT = 4'h6; // arbitrary value
  localparam int         CODE_MSB       = 7;
  localparam int         CODE_LSB       = 4;
  localparam int         BLK_BIT        = 1;
  localparam int         RW_BIT         = 0;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam int         ADDR_W         = 9;
  localparam int         MEM_BYTES      = 512;
  localparam int         PAGE_BYTES     = 16;
  localparam logic [7:0] ERASED         = 8'hff;
  localparam int         CLK_HZ         = 125_000_000;
  localparam int         TWC_MS         = 5;
  localparam int         WRITE_CYCLES   = CLK_HZ / 1000 * TWC_MS;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_CTRL  = 7'b0000010,
    ST_ACK   = 7'b0000100,
    ST_WADDR = 7'b0001000,
    ST_WDATA = 7'b0010000,
    ST_RDATA = 7'b0100000,
    ST_RACK  = 7'b1000000
  } sesp_state_t;

endpackage : sesp_pkg

// ### shared/sesp_wc_if.sv
// write-cycle request and completion, each a toggle crossing the clock domains
interface sesp_wc_if;
  logic reqTgl;
  logic doneTgl;
  modport link  (output reqTgl, input doneTgl);
  modport timer (input reqTgl, output doneTgl);
endinterface : sesp_wc_if

// ### hw/sesp_wr_timer.sv
module sesp_wr_timer #(
  parameter int WRITE_CYCLES = sesp_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  sesp_wc_if.timer wc
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  logic          reqS1_r;
  logic          reqS2_r;
  logic          reqD_r;
  logic          busy_r;
  logic [CW-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // request toggle synchroniser; the detector compares the second stage with its delayed copy
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
      reqD_r  <= 1'b0;
    end
    else
    begin
      reqS1_r <= wc.reqTgl;
      reqS2_r <= reqS1_r;
      reqD_r  <= reqS2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed write cycle; completion goes back as a toggle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy_r     <= 1'b0;
      cnt_r      <= '0;
      wc.doneTgl <= 1'b0;
    end
    else if (reqS2_r ^ reqD_r)
    begin
      busy_r <= 1'b1;
      cnt_r  <= CW'(WRITE_CYCLES - 1);
    end
    else if (busy_r)
    begin
      if (cnt_r == '0)
      begin
        busy_r     <= 1'b0;
        wc.doneTgl <= ~wc.doneTgl;
      end
      else
        cnt_r <= cnt_r - CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_wcDone;
    busy_r && cnt_r == '0 |=> !busy_r && $changed(wc.doneTgl);
  endproperty
  a_wcDone: assert property (p_wcDone) else $error("write cycle end not signalled");

endmodule : sesp_wr_timer

// ### tb/sesp_bus_master.sv
////////////////////////////////////////////////////////////////////////////////
// behavioural two-wire master: drives clock and pulls data low, paced by clk falls
module sesp_bus_master #(
  parameter int HALF = 5
) (
  input  wire logic       clk,
  output logic            scl,
  output logic            mOe,
  input  wire logic       sda,
  output logic            resValid,
  output logic [7:0]      resData
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles with both lines high; clock stands still between frames
  initial
  begin
    scl = 1'b1;
    mOe = 1'b0;
    resValid = 1'b0;
    resData = 8'h00;
  end

  // one phase; 40 ns keeps each level well above four link samples
  task automatic wt();
    repeat (HALF) @(negedge clk);
  endtask : wt

  // from a low clock the data is raised first, so this doubles as repeated start
  task automatic start();
    if (scl === 1'b0)
    begin
      wt();
      mOe = 1'b0;
      wt();
      scl = 1'b1;
      wt();
    end
    mOe = 1'b1;
    wt();
    scl = 1'b0;
  endtask : start

  // data rises while the clock is high
  task automatic stop();
    wt();
    mOe = 1'b1;
    wt();
    scl = 1'b1;
    wt();
    mOe = 1'b0;
    wt();
  endtask : stop

  // data moves only a phase after the clock fell, so the device never sees a false start
  task automatic bitX(input logic b, output logic s);
    wt();
    mOe = !b;
    wt();
    scl = 1'b1;
    wt();
    s = sda;
    scl = 1'b0;
  endtask : bitX

  task automatic report(input logic [7:0] v);
    resData = v;
    resValid = 1'b1;
    @(negedge clk);
    resValid = 1'b0;
  endtask : report

  // msb first, ninth clock released for the device; reports the sampled level
  task automatic xmit(input logic [7:0] b, output logic ackLvl);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitX(b[i], s);
    end
    bitX(1'b1, ackLvl);
    report({7'h00, ackLvl});
  endtask : xmit

  // released line reads the pull-up unless the device drives it
  task automatic recv(input logic ackIt);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--)
    begin
      bitX(1'b1, s);
      v[i] = s;
    end
    bitX(!ackIt, s);
    report(v);
  endtask : recv

endmodule : sesp_bus_master

// ### tb/serial_eeprom_slave_protocol_tb_top.sv
module serial_eeprom_slave_protocol_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [3:0] TCODE = sesp_pkg::TYPE_CODE_DFLT;
  localparam int         WCYC  = 300;

  logic        clk     = 1'b0;
  logic        linkClk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wpIn    = 1'b0;
  logic        scl;
  logic        mOe;
  logic        sdaWire;
  logic        sdaOut;
  logic        sdaOe;
  logic        resValid;
  logic [7:0]  resData;
  logic [8:0]  expQ[$];
  logic [8:0]  e;
  logic [7:0]  mem[512];
  logic [8:0]  ptr;
  logic [31:0] seed = 32'h0000005c;
  logic        lvl;
  int          nErrors = 0;
  int          totalChecks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // clocks of unrelated phase; open-drain wire with pull-up
  always #4 clk = ~clk;
  always #3 linkClk = ~linkClk;
  assign sdaWire = ~((sdaOe & ~sdaOut) | mOe);

  sesp_slave #(
    .TYPE_CODE    (TCODE),
    .WRITE_CYCLES (WCYC)
  ) i_dut (
    .clk     (clk),
    .sys_rst (sys_rst),
    .linkClk (linkClk),
    .sclIn   (scl),
    .sdaIn   (sdaWire),
    .wpIn    (wpIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe)
  );

  sesp_bus_master i_mst (
    .clk      (clk),
    .scl      (scl),
    .mOe      (mOe),
    .sda      (sdaWire),
    .resValid (resValid),
    .resData  (resData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // the two bits after the code are random, so matching must ignore them
  function automatic logic [7:0] ctrl(input logic [3:0] code, input logic blk, input logic rd);
    logic [7:0] r;
    r = rnd();
    return {code, r[1:0], blk, rd};
  endfunction : ctrl

  // bit 8 of a note marks a result whose value matters
  task automatic note(input logic care, input logic [7:0] v);
    expQ.push_back({care, v});
  endtask : note

  task automatic tx(input logic [7:0] b, input logic expAck);
    note(1'b1, {7'h00, !expAck});
    i_mst.xmit(b, lvl);
  endtask : tx

  // the first poll shows whether a write cycle runs; then poll to completion
  task automatic poll(input logic busy, input logic blk);
    int n;
    n = 0;
    i_mst.start();
    tx(ctrl(TCODE, blk, 1'b0), !busy);
    i_mst.stop();
    while (lvl !== 1'b0 && n < 40)
    begin
      i_mst.start();
      note(1'b0, 8'h00);
      i_mst.xmit(ctrl(TCODE, blk, 1'b0), lvl);
      i_mst.stop();
      n++;
    end
    if (lvl !== 1'b0)
    begin
      nErrors++;
      $display("Error at %0t: write cycle never ended", $time);
    end
  endtask : poll

  // buffered bytes land at offset+k within the page, the latest one winning
  task automatic wrSeq(input logic [8:0] a, input int n, input logic prot);
    logic [7:0] d;
    i_mst.start();
    tx(ctrl(TCODE, a[8], 1'b0), 1'b1);
    tx(a[7:0], 1'b1);
    for (int k = 0; k < n; k++)
    begin
      d = rnd();
      tx(d, 1'b1);
      if (!prot)
      begin
        mem[{a[8:4], a[3:0] + 4'(k)}] = d;
      end
    end
    i_mst.stop();
    ptr = {a[8:4], a[3:0] + 4'(n)};
  endtask : wrSeq

  // read from the pointer; the block bit of the control byte sets its top bit
  task automatic rdSeq(input logic blk, input int n);
    i_mst.start();
    tx(ctrl(TCODE, blk, 1'b1), 1'b1);
    ptr[8] = blk;
    for (int k = 0; k < n; k++)
    begin
      note(1'b1, mem[ptr]);
      ptr = ptr + 9'h001;
      i_mst.recv(k != n - 1);
    end
    i_mst.stop();
  endtask : rdSeq

  task automatic rrd(input logic [8:0] a, input int n);
    i_mst.start();
    tx(ctrl(TCODE, a[8], 1'b0), 1'b1);
    tx(a[7:0], 1'b1);
    // the word address just sent replaces whatever the last access left in the pointer
    ptr = a;
    rdSeq(a[8], n);
  endtask : rrd

  task automatic conclude();
    if (expQ.size() != 0)
    begin
      nErrors++;
      $display("Error at %0t: %0d results missing", $time, expQ.size());
    end
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  // takes the oldest note off the queue for every result the master reports
  always @(posedge clk)
  begin
    if (resValid === 1'b1)
    begin
      totalChecks++;
      if (expQ.size() == 0)
      begin
        nErrors++;
        $display("Error at %0t: unexpected result %h", $time, resData);
      end
      else
      begin
        e = expQ.pop_front();
        if (e[8] && resData !== e[7:0])
        begin
          nErrors++;
          $display("Error at %0t: got %h expected %h", $time, resData, e[7:0]);
        end
      end
    end
  end

  // a run needs about 12k cycles; the watchdog allows plenty beyond that
  initial
  begin
    repeat (60000) @(posedge clk);
    nErrors++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hff;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int j = 1; j < 16; j++)
    begin
      i_mst.start();
      tx(ctrl(TCODE ^ 4'(j), j[0], j[1]), 1'b0);
      i_mst.stop();
    end
    wrSeq(9'h03e, 18, 1'b0);
    poll(1'b1, 1'b0);
    rrd(9'h030, 16);
    wrSeq(9'h034, 1, 1'b0);
    poll(1'b1, 1'b0);
    rdSeq(1'b0, 2);
    wrSeq(9'h1fe, 1, 1'b0);
    poll(1'b1, 1'b1);
    rrd(9'h1fe, 4);
    @(negedge clk);
    wpIn = 1'b1;
    repeat (4) @(negedge clk);
    wrSeq(9'h034, 1, 1'b1);
    poll(1'b0, 1'b0);
    rrd(9'h034, 1);
    wpIn = 1'b0;
    repeat (4) @(negedge clk);
    conclude();
  end

endmodule : serial_eeprom_slave_protocol_tb_top
